// file: rtl/rfsgc_pkg.sv
// constants, field layout and carrier types for the rf_link_status and gain-control register bank
//
// Function
// - read-only 3-bit sequencer phase: idle, wait send, send, wait rx, wait data, rx, loopback.
// - read-only 4-bit field shows the gear chosen by dynamic power control.
// - carrier-lock bit set only with field on, frequency valid and loop locked.
// - checksum-good when crc is zero, or residue when inverted crc is used.
// - own-field bit is 1 while the transmitter drivers generate a field.
// - external-field bit is 1 when filtered level detectors sense a foreign field.
// - fault code: none, early field, field in window, no field, peer dropped.
// - fault code valid only with fault interrupt; cleared when field driver turns on, unless a new fault arrives in that same cycle, which wins.
// - decoder-armed bit is 1 once the decoder is enabled and ready for data.
// - encoder-busy bit is 1 while transmitting, 0 when the encoder idles.
// - decoder-busy bit is 1 while receiving, 0 when the decoder idles.
// - live 10-bit gain code; zero most sensitive, all ones most robust.
// - 2-bit target selector: low, middle, high reference; code three reserved.
// - one gain update period lasts the programmed time constant plus one cycles.
// - source bit picks card static value at 0, reader static value at 1.
// - writing the load bit copies the selected static value; bit self-clears; the load is ignored in frozen fixed operation.
// - fixed operation: choice 0 follows static value, choice 1 keeps frozen setting.
// - changing the choice bit never reloads the divider; only the load bit does.
// - loop enable 0 holds the divider fixed, 1 runs closed-loop control.
// - two writable 10-bit static values: reader in upper field, card in lower.
package rfsgc_pkg;

	// ==========================================================
	// register map (printed offsets are word indices)
	localparam logic [7:0] IDX_STATUS  = 8'h1D;
	localparam logic [7:0] IDX_CONFIG  = 8'h1E;
	localparam logic [7:0] IDX_STATIC  = 8'h1F;
	localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
	localparam logic [7:0] ADDR_CONFIG = 8'(IDX_CONFIG * 4);
	localparam logic [7:0] ADDR_STATIC = 8'(IDX_STATIC * 4);

	// ==========================================================
	// status word field positions
	localparam int ST_PHASE_LSB = 24;
	localparam int ST_GEAR_LSB  = 20;
	localparam int ST_LOCK      = 19;
	localparam int ST_CRC       = 18;
	localparam int ST_OWN       = 17;
	localparam int ST_EXT       = 16;
	localparam int ST_FAULT_LSB = 13;
	localparam int ST_ARMED     = 12;
	localparam int ST_ENC       = 11;
	localparam int ST_DEC       = 10;
	localparam int ST_GAIN_LSB  = 0;

	// ==========================================================
	// config and static word field positions
	localparam int CFG_TGT_LSB = 14;
	localparam int CFG_TC_LSB  = 4;
	localparam int CFG_SRC     = 3;
	localparam int CFG_LOAD    = 2;
	localparam int CFG_CHOICE  = 1;
	localparam int CFG_ON      = 0;
	localparam int VAL_RDR_LSB = 10;
	localparam int VAL_CRD_LSB = 0;

	// ==========================================================
	// encodings and reset values
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0, PH_WAIT_TX = 3'h1, PH_TX = 3'h2, PH_WAIT_RX = 3'h3,
		PH_WAIT_DATA = 3'h4, PH_RX = 3'h5, PH_LOOPBACK = 3'h6, PH_RSVD = 3'h7
	} rfsgc_phase_t;

	typedef enum logic [2:0] {
		FLT_NONE = 3'h0, FLT_EARLY_FIELD = 3'h1, FLT_FIELD_IN_WIN = 3'h2,
		FLT_NO_FIELD = 3'h3, FLT_PEER_DROP = 3'h4
	} rfsgc_fault_t;

	typedef struct packed {
		logic [1:0] gain_target_sel;    // reference select
		logic [9:0] gain_update_period; // time constant
		logic       static_gain_src;    // 0 card, 1 reader
		logic       fixed_gain_choice;  // 0 static, 1 frozen
		logic       gain_loop_on;       // closed loop enable
	} rfsgc_cfg_t;

	typedef struct packed {
		logic [9:0] reader_static_gain;
		logic [9:0] card_static_gain;
	} rfsgc_static_t;

	localparam rfsgc_cfg_t    CFG_RESET    = '0;
	localparam rfsgc_static_t STATIC_RESET = '0;
	localparam logic [9:0]    GAIN_RESET   = 10'h000;
	localparam logic [9:0]    GAIN_MAX     = 10'h3FF;
	localparam logic [9:0]    TC_MIN       = 10'h004;

endpackage

// file: rtl/rfsgc_top.sv
// apb register bank with rf_link_status word and receive gain loop
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module rfsgc_top #(
	parameter int          CRC_W       = 16,     // running crc width
	parameter logic [15:0] CRC_RESIDUE = 16'h0000 // residue for inverted crc
) (
	input  wire logic        pclk,            // 50 MHz bus clock
	input  wire logic        presetn,         // async reset, active low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [7:0]  paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error, unmapped address
	input  wire logic [2:0]  xcv_phase,       // sequencer phase
	input  wire logic [3:0]  power_ctrl_gear, // dynamic power control gear
	input  wire logic        field_present,   // field on
	input  wire logic        freq_valid,      // carrier frequency ok
	input  wire logic        pll_locked,      // loop locked
	input  wire logic [15:0] crc_value,       // running crc register
	input  wire logic        crc_inverted,    // inverted crc in use
	input  wire logic        drivers_on,      // transmitter drivers active
	input  wire logic        ext_level_det,   // filtered level detector
	input  wire logic        fault_event,     // active-mode fault pulse
	input  wire logic [2:0]  fault_cause,     // cause with fault_event
	input  wire logic        field_driver_on, // field driver enable bit
	input  wire logic        decoder_ready,   // decoder enabled and ready
	input  wire logic        encoder_active,  // transmission ongoing
	input  wire logic        decoder_active,  // reception ongoing
	input  wire logic        level_high,      // rx level above target
	input  wire logic        level_low,       // rx level below target
	output logic      [9:0]  rx_divider,      // gain code to receive divider
	output logic      [1:0]  gain_target_sel  // reference select to analog
);

	// ==========================================================
	// elaboration checks
	// the crc input is 16 bits, so a wider check cannot be served
	if (CRC_W < 1 || CRC_W > 16) begin : g_bad_crc_w
		$error("rfsgc_top: CRC_W must be 1 to 16");
	end

	// ==========================================================
	// bus decode
	logic        setup_ph;
	logic        wr_acc;
	logic        hit_status;
	logic        hit_config;
	logic        hit_static;
	logic        hit_any;
	logic        load_pulse;
	logic [9:0]  sel_static;

	// decode shared by read capture and write commit
	always_comb begin
		hit_status = 1'b0;
		hit_config = 1'b0;
		hit_static = 1'b0;
		if (paddr == rfsgc_pkg::ADDR_STATUS) begin
			hit_status = 1'b1;
		end else if (paddr == rfsgc_pkg::ADDR_CONFIG) begin
			hit_config = 1'b1;
		end else if (paddr == rfsgc_pkg::ADDR_STATIC) begin
			hit_static = 1'b1;
		end
	end

	// zero wait states: read data is captured in the setup cycle
	assign hit_any  = hit_status | hit_config | hit_static;
	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite & hit_any;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hit_any;

	// ==========================================================
	// software registers
	rfsgc_pkg::rfsgc_cfg_t    cfg;
	rfsgc_pkg::rfsgc_cfg_t    next_cfg;
	rfsgc_pkg::rfsgc_static_t stat_val;
	rfsgc_pkg::rfsgc_static_t next_stat_val;

	// load is a strobe only, never stored, so it reads back as zero
	assign load_pulse = wr_acc & hit_config & pwdata[rfsgc_pkg::CFG_LOAD];

	// writes to the status word are ignored, it holds no storage
	always_comb begin
		next_cfg      = cfg;
		next_stat_val = stat_val;
		if (wr_acc && hit_config) begin
			next_cfg.gain_target_sel    = pwdata[rfsgc_pkg::CFG_TGT_LSB +: 2];
			next_cfg.gain_update_period = pwdata[rfsgc_pkg::CFG_TC_LSB +: 10];
			next_cfg.static_gain_src    = pwdata[rfsgc_pkg::CFG_SRC];
			next_cfg.fixed_gain_choice  = pwdata[rfsgc_pkg::CFG_CHOICE];
			next_cfg.gain_loop_on       = pwdata[rfsgc_pkg::CFG_ON];
		end
		if (wr_acc && hit_static) begin
			next_stat_val.reader_static_gain = pwdata[rfsgc_pkg::VAL_RDR_LSB +: 10];
			next_stat_val.card_static_gain   = pwdata[rfsgc_pkg::VAL_CRD_LSB +: 10];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg      <= rfsgc_pkg::CFG_RESET;
			stat_val <= rfsgc_pkg::STATIC_RESET;
		end else begin
			cfg      <= next_cfg;
			stat_val <= next_stat_val;
		end
	end

	// reserved target code 11b is passed through unchanged to the analog side
	assign gain_target_sel = cfg.gain_target_sel;

	// ==========================================================
	// status capture
	logic [2:0]  phase_q;
	logic [3:0]  gear_q;
	logic        lock_q;
	logic        crc_ok_q;
	logic        own_q;
	logic        ext_q;
	logic [2:0]  fault_q;
	logic        armed_q;
	logic        enc_q;
	logic        dec_q;
	logic        drv_prev;
	logic [2:0]  next_fault;
	logic        crc_good;
	logic        drv_rise;
	logic [CRC_W-1:0] crc_cut;

	assign crc_cut  = crc_value[CRC_W-1:0];
	assign crc_good = crc_inverted ? (crc_cut == CRC_RESIDUE[CRC_W-1:0])
	                               : (crc_cut == '0);
	assign drv_rise = field_driver_on & ~drv_prev;

	// a new fault in the same cycle as the driver turn-on wins over the clear
	always_comb begin
		next_fault = fault_q;
		if (fault_event) begin
			next_fault = fault_cause;
		end else if (drv_rise) begin
			next_fault = rfsgc_pkg::FLT_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q  <= rfsgc_pkg::PH_IDLE;
			gear_q   <= 4'h0;
			lock_q   <= 1'b0;
			crc_ok_q <= 1'b0;
			own_q    <= 1'b0;
			ext_q    <= 1'b0;
			fault_q  <= rfsgc_pkg::FLT_NONE;
			armed_q  <= 1'b0;
			enc_q    <= 1'b0;
			dec_q    <= 1'b0;
			drv_prev <= 1'b0;
		end else begin
			phase_q  <= xcv_phase;
			gear_q   <= power_ctrl_gear;
			lock_q   <= field_present & freq_valid & pll_locked;
			crc_ok_q <= crc_good;
			own_q    <= drivers_on;
			ext_q    <= ext_level_det;
			fault_q  <= next_fault;
			armed_q  <= decoder_ready;
			enc_q    <= encoder_active;
			dec_q    <= decoder_active;
			drv_prev <= field_driver_on;
		end
	end

	// ==========================================================
	// gain loop: period counter and divider
	logic [9:0] period_cnt;
	logic [9:0] next_period_cnt;
	logic [9:0] next_rx_divider;
	logic       tick;
	logic       load_ok;

	// the counter trusts software to keep the constant at four or more
	assign tick       = cfg.gain_loop_on & (period_cnt >= cfg.gain_update_period);
	assign sel_static = cfg.static_gain_src ? stat_val.reader_static_gain
	                                        : stat_val.card_static_gain;
	// a frozen fixed setting ignores loads, everything else accepts them
	assign load_ok    = cfg.gain_loop_on | ~cfg.fixed_gain_choice;

	always_comb begin
		next_period_cnt = period_cnt;
		next_rx_divider = rx_divider;
		if (!cfg.gain_loop_on) begin
			next_period_cnt = 10'h000;
		end else if (tick) begin
			next_period_cnt = 10'h000;
		end else begin
			next_period_cnt = period_cnt + 10'h001;
		end
		// step toward the target once per period, saturating at the ends
		if (tick) begin
			if (level_high && rx_divider != rfsgc_pkg::GAIN_MAX) begin
				next_rx_divider = rx_divider + 10'h001;
			end else if (level_low && !level_high && rx_divider != rfsgc_pkg::GAIN_RESET) begin
				next_rx_divider = rx_divider - 10'h001;
			end
		end
		// a load overrides the loop step; the choice bit alone never reloads
		if (load_pulse && load_ok) begin
			next_rx_divider = sel_static;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt <= 10'h000;
			rx_divider <= rfsgc_pkg::GAIN_RESET;
		end else begin
			period_cnt <= next_period_cnt;
			rx_divider <= next_rx_divider;
		end
	end

	// ==========================================================
	// read data
	logic [31:0] rd_word;
	logic [31:0] next_prdata;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_status) begin
			rd_word[rfsgc_pkg::ST_PHASE_LSB +: 3] = phase_q;
			rd_word[rfsgc_pkg::ST_GEAR_LSB +: 4]  = gear_q;
			rd_word[rfsgc_pkg::ST_LOCK]           = lock_q;
			rd_word[rfsgc_pkg::ST_CRC]            = crc_ok_q;
			rd_word[rfsgc_pkg::ST_OWN]            = own_q;
			rd_word[rfsgc_pkg::ST_EXT]            = ext_q;
			rd_word[rfsgc_pkg::ST_FAULT_LSB +: 3] = fault_q;
			rd_word[rfsgc_pkg::ST_ARMED]          = armed_q;
			rd_word[rfsgc_pkg::ST_ENC]            = enc_q;
			rd_word[rfsgc_pkg::ST_DEC]            = dec_q;
			rd_word[rfsgc_pkg::ST_GAIN_LSB +: 10] = rx_divider;
		end else if (hit_config) begin
			rd_word[rfsgc_pkg::CFG_TGT_LSB +: 2] = cfg.gain_target_sel;
			rd_word[rfsgc_pkg::CFG_TC_LSB +: 10] = cfg.gain_update_period;
			rd_word[rfsgc_pkg::CFG_SRC]          = cfg.static_gain_src;
			rd_word[rfsgc_pkg::CFG_CHOICE]       = cfg.fixed_gain_choice;
			rd_word[rfsgc_pkg::CFG_ON]           = cfg.gain_loop_on;
		end else if (hit_static) begin
			rd_word[rfsgc_pkg::VAL_RDR_LSB +: 10] = stat_val.reader_static_gain;
			rd_word[rfsgc_pkg::VAL_CRD_LSB +: 10] = stat_val.card_static_gain;
		end
		next_prdata = prdata;
		if (setup_ph && !pwrite) begin
			next_prdata = rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end

	// ==========================================================
	// assertions
	property p_lock_cause;
		@(posedge pclk) disable iff (!presetn)
		lock_q |-> $past(field_present) && $past(freq_valid) && $past(pll_locked);
	endproperty
	a_lock_cause: assert property (p_lock_cause) else $error("lock bit without its three causes");

	property p_crc_zero;
		@(posedge pclk) disable iff (!presetn)
		(!crc_inverted && crc_cut == '0) |=> crc_ok_q;
	endproperty
	a_crc_zero: assert property (p_crc_zero) else $error("crc zero not reported good");

	property p_fault_set;
		@(posedge pclk) disable iff (!presetn)
		fault_event |=> fault_q == $past(fault_cause);
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault code not captured");

	property p_fault_clear;
		@(posedge pclk) disable iff (!presetn)
		(field_driver_on && !drv_prev && !fault_event) |=> fault_q == rfsgc_pkg::FLT_NONE;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault code not cleared by driver on");

	property p_period_gap;
		@(posedge pclk) disable iff (!presetn)
		(tick && cfg.gain_update_period >= rfsgc_pkg::TC_MIN && !wr_acc) |=> !tick [*4];
	endproperty
	a_period_gap: assert property (p_period_gap) else $error("gain update period too short");

	property p_load_copy;
		@(posedge pclk) disable iff (!presetn)
		(load_pulse && load_ok) |=> rx_divider == $past(sel_static);
	endproperty
	a_load_copy: assert property (p_load_copy) else $error("load did not copy static gain");

	property p_fixed_hold;
		@(posedge pclk) disable iff (!presetn)
		(!cfg.gain_loop_on && !load_pulse) |=> $stable(rx_divider);
	endproperty
	a_fixed_hold: assert property (p_fixed_hold) else $error("divider moved in fixed operation");

	property p_frozen;
		@(posedge pclk) disable iff (!presetn)
		(!cfg.gain_loop_on && cfg.fixed_gain_choice) |=> $stable(rx_divider);
	endproperty
	a_frozen: assert property (p_frozen) else $error("frozen divider changed");

	property p_step_up;
		@(posedge pclk) disable iff (!presetn)
		(tick && level_high && rx_divider != rfsgc_pkg::GAIN_MAX && !load_pulse)
			|=> rx_divider == $past(rx_divider) + 10'h001;
	endproperty
	a_step_up: assert property (p_step_up) else $error("gain did not step up");

	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !hit_any) |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");

	// the loop must also step down and stop at both ends of the code range
	property p_step_down;
		@(posedge pclk) disable iff (!presetn)
		(tick && level_low && !level_high && rx_divider != rfsgc_pkg::GAIN_RESET && !load_pulse)
			|=> rx_divider == $past(rx_divider) - 10'h001;
	endproperty
	a_step_down: assert property (p_step_down) else $error("gain did not step down");

	property p_sat_top;
		@(posedge pclk) disable iff (!presetn)
		(tick && level_high && rx_divider == rfsgc_pkg::GAIN_MAX && !load_pulse) |=> rx_divider == rfsgc_pkg::GAIN_MAX;
	endproperty
	a_sat_top: assert property (p_sat_top) else $error("gain wrapped past the most robust code");

	property p_sat_bottom;
		@(posedge pclk) disable iff (!presetn)
		(tick && !level_high && rx_divider == rfsgc_pkg::GAIN_RESET && !load_pulse)
			|=> rx_divider == rfsgc_pkg::GAIN_RESET;
	endproperty
	a_sat_bottom: assert property (p_sat_bottom) else $error("gain wrapped past the most sensitive code");

	// status fields show their source one edge later
	property p_status_follow;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> phase_q == $past(xcv_phase) && gear_q == $past(power_ctrl_gear);
	endproperty
	a_status_follow: assert property (p_status_follow) else $error("phase or gear not captured");

	property p_flag_follow;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> own_q == $past(drivers_on) && ext_q == $past(ext_level_det);
	endproperty
	a_flag_follow: assert property (p_flag_follow) else $error("field flags not captured");

	property p_engine_follow;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> armed_q == $past(decoder_ready) && enc_q == $past(encoder_active) && dec_q == $past(decoder_active);
	endproperty
	a_engine_follow: assert property (p_engine_follow) else $error("codec flags not captured");

	// without a new fault or a driver turn-on the code must not move
	property p_fault_hold;
		@(posedge pclk) disable iff (!presetn)
		(!fault_event && !drv_rise) |=> $stable(fault_q);
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault code changed without cause");

endmodule

// file: verification/rfsgc_tb.sv
// self-checking bench for the rf_link_status and gain-control register bank
`timescale 1ns/10ps
module tb;
	// ==========================================================
	// table row: status inputs beside the status word they give
	typedef struct packed {
		logic [2:0]  ph;
		logic [3:0]  gear;
		logic [2:0]  lock_in;
		logic [15:0] crc;
		logic        inv;
		logic [4:0]  flags;
		logic [31:0] exp;
	} rfsgc_row_t;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  xcv_phase = 3'h0;
	logic [3:0]  power_ctrl_gear = 4'h0;
	logic [2:0]  lock_in = 3'h0;
	logic [15:0] crc_value = 16'h0000;
	logic        crc_inverted = 1'b0;
	logic [4:0]  flags = 5'h00;
	logic        fault_event = 1'b0;
	logic [2:0]  fault_cause = 3'h0;
	logic        field_driver_on = 1'b0;
	logic        level_high = 1'b0;
	logic        level_low = 1'b0;
	logic [9:0]  rx_divider;
	logic [1:0]  gain_target_sel;
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        err;
	logic [9:0]  prev;
	int          n;
	rfsgc_row_t  rows [8];

	always #10 pclk = ~pclk;

	rfsgc_top dut (
		.pclk            (pclk),
		.presetn         (presetn),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.xcv_phase       (xcv_phase),
		.power_ctrl_gear (power_ctrl_gear),
		.field_present   (lock_in[2]),
		.freq_valid      (lock_in[1]),
		.pll_locked      (lock_in[0]),
		.crc_value       (crc_value),
		.crc_inverted    (crc_inverted),
		.drivers_on      (flags[4]),
		.ext_level_det   (flags[3]),
		.fault_event     (fault_event),
		.fault_cause     (fault_cause),
		.field_driver_on (field_driver_on),
		.decoder_ready   (flags[2]),
		.encoder_active  (flags[1]),
		.decoder_active  (flags[0]),
		.level_high      (level_high),
		.level_low       (level_low),
		.rx_divider      (rx_divider),
		.gain_target_sel (gain_target_sel)
	);

	// ==========================================================
	// verdict and hang guard; the ceiling is well above the expected run
	task conclude;
		$display("checks %0d, failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			conclude();
		end
	end

	// ==========================================================
	// compares and bus cycles
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chk_gain(input logic [9:0] got, input logic [9:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// holds the request until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// waits until rx_divider moves, counting edges, bounded at 40; a value read
	// at an edge is the one registered an edge earlier, so stimulus stays on edges
	task wait_step;
		prev = rx_divider;
		n = 0;
		do begin
			@(posedge pclk);
			n = n + 1;
		end while (rx_divider === prev && n < 40);
	endtask

	initial begin
		rows[0] = '{3'h1, 4'h5, 3'h7, 16'h0000, 1'b0, 5'h12, 32'h015E0800};
		rows[1] = '{3'h2, 4'hF, 3'h6, 16'h1234, 1'b0, 5'h0D, 32'h02F11400};
		rows[2] = '{3'h3, 4'h0, 3'h3, 16'h0000, 1'b1, 5'h00, 32'h03040000};
		rows[3] = '{3'h4, 4'h1, 3'h5, 16'hFFFF, 1'b1, 5'h00, 32'h04100000};
		rows[4] = '{3'h5, 4'h8, 3'h7, 16'h0001, 1'b0, 5'h01, 32'h05880400};
		rows[5] = '{3'h6, 4'h0, 3'h0, 16'h0001, 1'b0, 5'h00, 32'h06000000};
		rows[6] = '{3'h7, 4'h0, 3'h0, 16'h0001, 1'b0, 5'h00, 32'h07000000};
		rows[7] = '{3'h0, 4'h0, 3'h0, 16'h0001, 1'b0, 5'h00, 32'h00000000};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// reset values of the config and static words
		apb(1'b0, rfsgc_pkg::ADDR_CONFIG, 32'h0);
		chk_word(rd, 32'h0);
		apb(1'b0, rfsgc_pkg::ADDR_STATIC, 32'h0);
		chk_word(rd, 32'h0);
		$display("test reset done");
		// status table
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			xcv_phase <= rows[i].ph;
			power_ctrl_gear <= rows[i].gear;
			lock_in <= rows[i].lock_in;
			crc_value <= rows[i].crc;
			crc_inverted <= rows[i].inv;
			flags <= rows[i].flags;
			apb(1'b0, rfsgc_pkg::ADDR_STATUS, 32'h0);
			chk_word(rd, rows[i].exp);
		end
		// status is read-only; unmapped address errors
		apb(1'b1, rfsgc_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		apb(1'b0, rfsgc_pkg::ADDR_STATUS, 32'h0);
		chk_word(rd, 32'h0);
		apb(1'b0, 8'h80, 32'h0);
		chk_word({31'h0, err}, 32'h1);
		$display("test status table done");
		// static values, time constant, source and choice read back, reserved bits read 0; target seen at its port
		apb(1'b1, rfsgc_pkg::ADDR_STATIC, 32'hFFFFFFFF);
		apb(1'b0, rfsgc_pkg::ADDR_STATIC, 32'h0);
		chk_word(rd, 32'h000FFFFF);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'hFFFF3FFA);
		apb(1'b0, rfsgc_pkg::ADDR_CONFIG, 32'h0);
		chk_word(rd, 32'h00003FFA);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'(k) << 14);
			@(negedge pclk);
			chk_word(32'(gain_target_sel), 32'(k));
		end
		$display("test config fields done");
		// static load from each source
		apb(1'b1, rfsgc_pkg::ADDR_STATIC, 32'h000A955A);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000008);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h0000000C);
		@(posedge pclk);
		chk_gain(rx_divider, 10'h2A5);
		apb(1'b0, rfsgc_pkg::ADDR_CONFIG, 32'h0);
		chk_word(rd, 32'h00000008);
		apb(1'b0, rfsgc_pkg::ADDR_STATUS, 32'h0);
		chk_word(rd, 32'h000002A5);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000000);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000004);
		@(posedge pclk);
		chk_gain(rx_divider, 10'h15A);
		// choice bit alone never reloads; frozen ignores load
		apb(1'b1, rfsgc_pkg::ADDR_STATIC, 32'h0);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000002);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000006);
		@(posedge pclk);
		chk_gain(rx_divider, 10'h15A);
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000000);
		repeat (3) @(posedge pclk);
		chk_gain(rx_divider, 10'h15A);
		$display("test static load done");
		// closed loop, period of time constant plus one
		level_high <= 1'b1;
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000041);
		wait_step();
		chk_gain(rx_divider, 10'h15B);
		wait_step();
		chk_word(32'(n), 32'd5);
		chk_gain(rx_divider, 10'h15C);
		level_high <= 1'b0;
		level_low <= 1'b1;
		wait_step();
		chk_gain(rx_divider, 10'h15B);
		// saturation at the most sensitive code
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000045);
		repeat (12) @(posedge pclk);
		chk_gain(rx_divider, 10'h000);
		level_low <= 1'b0;
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h00000000);
		$display("test gain loop done");
		// fault codes, cleared by the field driver turning on
		for (int c = 1; c < 5; c++) begin
			@(posedge pclk);
			fault_event <= 1'b1;
			fault_cause <= 3'(c);
			@(posedge pclk);
			fault_event <= 1'b0;
			apb(1'b0, rfsgc_pkg::ADDR_STATUS, 32'h0);
			chk_word(32'(rd[15:13]), 32'(c));
			@(posedge pclk);
			field_driver_on <= 1'b1;
			apb(1'b0, rfsgc_pkg::ADDR_STATUS, 32'h0);
			chk_word(32'(rd[15:13]), 32'h0);
			field_driver_on <= 1'b0;
		end
		// a fault in the same cycle as the driver turn-on wins over the clear
		@(posedge pclk);
		fault_event <= 1'b1;
		fault_cause <= 3'h3;
		field_driver_on <= 1'b1;
		@(posedge pclk);
		fault_event <= 1'b0;
		apb(1'b0, rfsgc_pkg::ADDR_STATUS, 32'h0);
		chk_word(32'(rd[15:13]), 32'h3);
		field_driver_on <= 1'b0;
		$display("test fault codes done");
		// mid-run reset clears the configuration and a pending fault code
		apb(1'b1, rfsgc_pkg::ADDR_CONFIG, 32'h0000C000);
		fault_event <= 1'b1;
		fault_cause <= 3'h4;
		@(posedge pclk);
		fault_event <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk_word(32'(gain_target_sel), 32'h0);
		apb(1'b0, rfsgc_pkg::ADDR_STATUS, 32'h0);
		chk_word(rd, 32'h0);
		apb(1'b0, rfsgc_pkg::ADDR_CONFIG, 32'h0);
		chk_word(rd, 32'h0);
		$display("test mid reset done");
		conclude();
	end
endmodule
